// file: rtl/hcsa_pkg.sv
// Purpose: constants and types shared by the host card sector access block.
// Assumes: byte offsets as seen on the host bus; word mode maps word address n to byte 2n.
// Notes: control and status bit positions are fixed here and nowhere else.
// Operation
// - after reset with default selects, configuration data comes from the card.
// - force-address bit makes the register image address replace the address pins.
// - force-mode bit makes the register mode copy replace the mode pin.
// - chip reset also resets the scan controller, same as the software reset bit.
// - mode 1, source 0, reset 0 configures from the card whatever start holds.
// - mode 0, source 0, start 1, reset 0 configures from the card.
// - mode 1, source 1, reset 0 takes configuration data from the host.
// - mode 1, start 0, reset 0 still picks card or host by source; the test scan port is never selected.
// - sector address is four bytes at 10h..13h; only low nibble of top used.
// - count at 14h, then command 03h at 15h starts the card read.
// - host sets lock request, polls host-lock-granted status bit 1 at 04h.
// - config-lock status bit 0 shows the scan controller owns the card.
// - reset bit with force-lock bit drops the scan controller's lock.
// - card-ready-for-command is bit 0 of status byte 05h.
// - data buffer is a 16-word FIFO aliased over 40h..7Fh.
// - byte mode pops on odd-offset reads; word mode pops on every read.
// - buffer ready when FIFO full during a sector read; host then reads 32 bytes.
// - buffer readiness shows on status bit 5 and on a dedicated pin.
// - buffer port is read-only when direction bit is 0, write-only when 1.
// - byte-mode reads hold the port word until its high byte is read.
package hcsa_pkg;
    // register byte offsets
    localparam logic [6:0] OFS_STATUS = 7'h04;
    localparam logic [6:0] OFS_LBA_LO = 7'h10;
    localparam logic [6:0] OFS_LBA_HI = 7'h12;
    localparam logic [6:0] OFS_SECCMD = 7'h14;
    localparam logic [6:0] OFS_CTRL = 7'h18;
    localparam logic [6:0] OFS_BUF_BASE = 7'h40;
    // control word fields
    localparam int CTRL_FORCE_LOCK = 0;
    localparam int CTRL_LOCK_REQ = 1;
    localparam int CTRL_FORCE_ADDR = 2;
    localparam int CTRL_FORCE_MODE = 3;
    localparam int CTRL_MODE = 4;
    localparam int CTRL_START = 5;
    localparam int CTRL_SOURCE = 6;
    localparam int CTRL_CFG_RESET = 7;
    localparam int CTRL_ADDR_LSB = 8;
    localparam logic [15:0] CTRL_RESET_VAL = 16'h0000;
    // status word fields
    localparam int STAT_CFG_LOCK = 0;
    localparam int STAT_HOST_LOCK = 1;
    localparam int STAT_BUF_READY = 5;
    localparam int STAT_BUF_DIR = 6;
    localparam int STAT_CARD_READY = 8;
    // commands and counts
    localparam logic [7:0] CMD_READ_SECTOR = 8'h03;
    localparam logic [16:0] WORDS_256_SECTORS = 17'h10000;
    localparam logic [4:0] BURST_WORDS = 5'h10;
    localparam int FIFO_WIDTH = 16;
    localparam int FIFO_DEPTH = 16;

    typedef enum logic [1:0] {
        SRC_NONE = 2'b00,
        SRC_CARD = 2'b01,
        SRC_HOST = 2'b10,
        SRC_TEST = 2'b11
    } hcsa_src_e;

    typedef enum logic [1:0] {
        OWN_NONE = 2'b00,
        OWN_HOST = 2'b01,
        OWN_CFG = 2'b10
    } hcsa_own_e;
endpackage : hcsa_pkg

// file: rtl/hcsa_top.sv
// Purpose: host port, card lock, sector read and configuration source select.
// Assumes: host strobes are synchronous to CLK; one access per strobe low period.
// Notes: only the read-sector path is built; the buffer direction is always read.
`timescale 1ns/1ps

module hcsa_fifo #(
    parameter int W = 16,
    parameter int D = 16
) (
    input wire logic clk,
    input wire logic rst,
    // filling side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [W-1:0] in_data,
    // draining side
    output logic out_valid,
    input wire logic out_ready,
    output logic [W-1:0] out_data,
    // levels
    output logic full,
    output logic empty
);
    localparam int AW = $clog2(D);
    typedef struct packed {
        logic [D-1:0][W-1:0] mem;
        logic [AW-1:0] wp;
        logic [AW-1:0] rp;
        logic [AW:0] cnt;
    } hcsa_fifo_s;
    hcsa_fifo_s s_q, s_d;
    logic push, pop;

    // handshakes; depth must be a power of two so pointers wrap freely
    assign full = (s_q.cnt == (AW+1)'(D));
    assign empty = (s_q.cnt == '0);
    assign in_ready = !full;
    assign out_valid = !empty;
    assign out_data = s_q.mem[s_q.rp];
    assign push = in_valid && !full;
    assign pop = out_ready && !empty;

    // next state
    always_comb begin
        s_d = s_q;
        if (push) begin
            s_d.mem[s_q.wp] = in_data;
            s_d.wp = s_q.wp + 1'b1;
        end
        if (pop) begin
            s_d.rp = s_q.rp + 1'b1;
        end
        s_d.cnt = s_q.cnt + (AW+1)'(push) - (AW+1)'(pop);
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end
endmodule : hcsa_fifo

module hcsa_top
    import hcsa_pkg::*;
(
    // clock and reset
    input wire logic CLK,
    input wire logic RST,
    // host bus
    input wire logic [6:0] HOST_ADDR,
    input wire logic [15:0] HOST_DATA_I,
    output logic [15:0] HOST_DATA_O,
    output logic HOST_DATA_OE,
    input wire logic HOST_CS_N,
    input wire logic HOST_RD_N,
    input wire logic HOST_WR_N,
    input wire logic HOST_BYTE_MODE,
    output logic BUFFER_READY_PIN,
    // configuration selects
    input wire logic CONFIG_MODE_PIN,
    input wire logic [2:0] CONFIG_ADDR_PINS,
    output logic [1:0] CONFIG_SOURCE,
    output logic [2:0] CONFIG_IMAGE_ADDRESS,
    output logic CONFIG_START,
    output logic CONFIG_CTRL_RESET,
    // configuration scan controller lock
    input wire logic CFG_LOCK_REQUEST,
    output logic CFG_LOCK_GRANT,
    // card side
    input wire logic CARD_READY_FOR_COMMAND,
    output logic CARD_CMD_VALID,
    output logic [27:0] CARD_SECTOR_ADDR,
    output logic [7:0] CARD_SECTOR_COUNT,
    input wire logic [15:0] CARD_DATA,
    input wire logic CARD_DATA_VALID,
    output logic CARD_DATA_READY
);
    typedef struct packed {
        logic [31:0] sector_address;
        logic [7:0] count;
        logic [15:0] ctrl;
        hcsa_own_e own;
        logic active;
        logic rdy;
        logic [16:0] remain;
        logic [4:0] burst;
        logic cmd;
        logic rd_prev;
        logic wr_prev;
        logic [15:0] rdata;
        hcsa_src_e src;
        logic [2:0] img_addr;
    } hcsa_top_s;
    hcsa_top_s s_q, s_d;

    logic rd, wr, rd_first, wr_first, is_buf, pop;
    logic [6:0] baddr, waddr;
    logic [1:0] be;
    logic [15:0] wdat, status, rv;
    logic fifo_valid, fifo_full, fifo_empty;
    logic [15:0] fifo_data;
    logic mode, buf_dir;

    // access decode; word mode addresses are word indices, scaled to bytes
    assign rd = !HOST_CS_N && !HOST_RD_N;
    assign wr = !HOST_CS_N && !HOST_WR_N;
    assign rd_first = rd && !s_q.rd_prev;
    assign wr_first = wr && !s_q.wr_prev;
    assign baddr = HOST_BYTE_MODE ? HOST_ADDR : {HOST_ADDR[5:0], 1'b0};
    assign waddr = {baddr[6:1], 1'b0};
    assign is_buf = baddr[6];
    assign be = HOST_BYTE_MODE ? (baddr[0] ? 2'b10 : 2'b01) : 2'b11;
    assign wdat = HOST_BYTE_MODE ? {HOST_DATA_I[7:0], HOST_DATA_I[7:0]} : HOST_DATA_I;
    assign buf_dir = 1'b0;

    // pop on odd byte or any word read; never while the port is write-only
    assign pop = rd_first && is_buf && !buf_dir && fifo_valid
        && (!HOST_BYTE_MODE || baddr[0]);

    // status word assembly
    always_comb begin
        status = '0;
        status[STAT_CFG_LOCK] = (s_q.own == OWN_CFG);
        status[STAT_HOST_LOCK] = (s_q.own == OWN_HOST);
        status[STAT_BUF_READY] = s_q.rdy;
        status[STAT_BUF_DIR] = buf_dir;
        status[STAT_CARD_READY] = CARD_READY_FOR_COMMAND;
    end

    // read mux; unmapped offsets read zero, buffer shows the held head word
    always_comb begin
        rv = '0;
        if (is_buf) begin
            rv = buf_dir ? 16'h0000 : fifo_data;
        end else begin
            case (waddr)
                OFS_STATUS: rv = status;
                OFS_LBA_LO: rv = s_q.sector_address[15:0];
                OFS_LBA_HI: rv = s_q.sector_address[31:16];
                OFS_SECCMD: rv = {8'h00, s_q.count};
                OFS_CTRL: rv = s_q.ctrl;
                default: rv = '0;
            endcase
        end
    end

    assign mode = s_q.ctrl[CTRL_FORCE_MODE] ? s_q.ctrl[CTRL_MODE] : CONFIG_MODE_PIN;

    // next state
    always_comb begin
        s_d = s_q;
        s_d.rd_prev = rd;
        s_d.wr_prev = wr;
        s_d.cmd = 1'b0;
        if (rd_first) begin
            s_d.rdata = HOST_BYTE_MODE ? {8'h00, (baddr[0] ? rv[15:8] : rv[7:0])} : rv;
        end
        // register writes by byte lane
        if (wr_first && !is_buf) begin
            case (waddr)
                OFS_LBA_LO: begin
                    if (be[0]) s_d.sector_address[7:0] = wdat[7:0];
                    if (be[1]) s_d.sector_address[15:8] = wdat[15:8];
                end
                OFS_LBA_HI: begin
                    if (be[0]) s_d.sector_address[23:16] = wdat[7:0];
                    if (be[1]) s_d.sector_address[31:24] = wdat[15:8];
                end
                OFS_SECCMD: begin
                    if (be[0]) s_d.count = wdat[7:0];
                    // card access only for the lock holder, and one command at a time
                    if (be[1] && wdat[15:8] == CMD_READ_SECTOR && s_q.own == OWN_HOST
                        && !s_q.active) begin
                        s_d.cmd = 1'b1;
                        s_d.active = 1'b1;
                        s_d.burst = '0;
                        s_d.remain = (be[0] ? wdat[7:0] : s_q.count) == 8'h00
                            ? WORDS_256_SECTORS
                            : {1'b0, (be[0] ? wdat[7:0] : s_q.count), 8'h00};
                    end
                end
                OFS_CTRL: begin
                    if (be[0]) s_d.ctrl[7:0] = wdat[7:0];
                    if (be[1]) s_d.ctrl[15:8] = wdat[15:8];
                end
                default: ;
            endcase
        end
        // buffer pops count down the transfer
        if (pop && s_q.active) begin
            s_d.remain = s_q.remain - 17'h00001;
            s_d.burst = s_q.burst + 5'h01;
            if (s_q.remain == 17'h00001) begin
                s_d.active = 1'b0;
            end
        end
        // ready latches on a full buffer and drops after one whole burst
        if (!s_d.active) begin
            s_d.rdy = 1'b0;
        end else if (s_q.rdy && s_d.burst == BURST_WORDS) begin
            s_d.rdy = 1'b0;
        end else if (!s_q.rdy && fifo_full) begin
            s_d.rdy = 1'b1;
            s_d.burst = '0;
        end
        // lock arbitration; host wins a tie, forcing with the reset bit frees the scan controller
        case (s_q.own)
            OWN_NONE: begin
                if (s_q.ctrl[CTRL_LOCK_REQ]) begin
                    s_d.own = OWN_HOST;
                end else if (CFG_LOCK_REQUEST && !s_q.ctrl[CTRL_FORCE_LOCK]) begin
                    s_d.own = OWN_CFG;
                end
            end
            OWN_HOST: begin
                if (!s_q.ctrl[CTRL_LOCK_REQ]) begin
                    s_d.own = OWN_NONE;
                end
            end
            OWN_CFG: begin
                if (!CFG_LOCK_REQUEST
                    || (s_q.ctrl[CTRL_FORCE_LOCK] && s_q.ctrl[CTRL_CFG_RESET])) begin
                    s_d.own = OWN_NONE;
                end
            end
            default: s_d.own = OWN_NONE;
        endcase
        // configuration source from mode, source select, start and reset
        if (s_q.ctrl[CTRL_CFG_RESET]) begin
            s_d.src = SRC_NONE;
        end else if (mode && !s_q.ctrl[CTRL_SOURCE]) begin
            s_d.src = SRC_CARD;
        end else if (mode && s_q.ctrl[CTRL_SOURCE]) begin
            s_d.src = SRC_HOST;
        end else if (!s_q.ctrl[CTRL_SOURCE] && s_q.ctrl[CTRL_START]) begin
            s_d.src = SRC_CARD;
        end else if (mode && !s_q.ctrl[CTRL_START]) begin
            s_d.src = SRC_TEST;
        end else begin
            s_d.src = SRC_NONE;
        end
        s_d.img_addr = s_q.ctrl[CTRL_FORCE_ADDR]
            ? s_q.ctrl[CTRL_ADDR_LSB +: 3] : CONFIG_ADDR_PINS;
    end

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            s_q <= '0;
            s_q.ctrl <= CTRL_RESET_VAL;
            s_q.own <= OWN_NONE;
            s_q.src <= SRC_CARD;
        end else begin
            s_q <= s_d;
        end
    end

    // buffer between card and host; a full buffer stalls the card
    hcsa_fifo #(
        .W(FIFO_WIDTH),
        .D(FIFO_DEPTH)
    ) u_fifo (
        .clk(CLK),
        .rst(RST),
        .in_valid(CARD_DATA_VALID && s_q.active),
        .in_ready(CARD_DATA_READY),
        .in_data(CARD_DATA),
        .out_valid(fifo_valid),
        .out_ready(pop),
        .out_data(fifo_data),
        .full(fifo_full),
        .empty(fifo_empty)
    );

    // outputs
    assign HOST_DATA_O = s_q.rdata;
    assign HOST_DATA_OE = rd && s_q.rd_prev;
    assign BUFFER_READY_PIN = s_q.rdy;
    assign CONFIG_SOURCE = s_q.src;
    assign CONFIG_IMAGE_ADDRESS = s_q.img_addr;
    assign CONFIG_START = s_q.ctrl[CTRL_START];
    assign CONFIG_CTRL_RESET = RST || s_q.ctrl[CTRL_CFG_RESET];
    assign CFG_LOCK_GRANT = (s_q.own == OWN_CFG);
    assign CARD_CMD_VALID = s_q.cmd;
    assign CARD_SECTOR_ADDR = s_q.sector_address[27:0];
    assign CARD_SECTOR_COUNT = s_q.count;

    default clocking cb @(posedge CLK); endclocking
    default disable iff (RST);

    a_lock_exclusive: assert property (!(CFG_LOCK_GRANT && status[STAT_HOST_LOCK]))
        else $error("both lock holders granted");
    a_host_grant: assert property (s_q.own == OWN_NONE && s_q.ctrl[CTRL_LOCK_REQ]
        |=> status[STAT_HOST_LOCK])
        else $error("host lock not granted");
    a_force_drop: assert property (CFG_LOCK_GRANT && s_q.ctrl[CTRL_FORCE_LOCK]
        && s_q.ctrl[CTRL_CFG_RESET] |=> !CFG_LOCK_GRANT)
        else $error("forced release ignored");
    a_ready_idle: assert property (!s_q.active |-> !BUFFER_READY_PIN)
        else $error("buffer ready while idle");
    a_ready_full: assert property (s_q.active && !s_q.rdy && fifo_full && !pop
        |=> BUFFER_READY_PIN && status[STAT_BUF_READY])
        else $error("full buffer not flagged ready");
    a_cmd_start: assert property (wr_first && waddr == OFS_SECCMD && be[1]
        && wdat[15:8] == CMD_READ_SECTOR && s_q.own == OWN_HOST && !s_q.active
        |=> CARD_CMD_VALID && s_q.active ##1 !CARD_CMD_VALID)
        else $error("read command not started");
    a_even_hold: assert property (rd_first && is_buf && HOST_BYTE_MODE && !baddr[0]
        |=> $stable(fifo_data) || $past(fifo_empty))
        else $error("even byte read advanced buffer");
    a_addr_override: assert property (s_q.ctrl[CTRL_FORCE_ADDR]
        && $stable(s_q.ctrl) |=> CONFIG_IMAGE_ADDRESS == $past(s_q.ctrl[10:8]))
        else $error("image address not overridden");
    a_card_default: assert property (!s_q.ctrl[CTRL_CFG_RESET] && mode
        && !s_q.ctrl[CTRL_SOURCE] |=> CONFIG_SOURCE == SRC_CARD)
        else $error("card source not selected");
endmodule : hcsa_top

// file: bench/hcsa_card_model.sv
// Purpose: behavioural card on the far side of the sector read port.
// Assumes: one word per valid/ready handshake; count 0 stands for 256 sectors.
// Notes: word n of a transfer is the low half of the sector address plus n.
`timescale 1ns/1ps

module hcsa_card_model (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // command side
    input wire logic slow,
    input wire logic cmd_valid,
    input wire logic [27:0] sector_addr,
    input wire logic [7:0] sector_count,
    output logic ready_for_command,
    output logic [7:0] n_cmds,
    // data side
    output logic data_valid = 1'b0,
    output logic [15:0] data = 16'h0000,
    input wire logic data_ready
);
    logic [16:0] left_q = 17'h00000;
    logic [15:0] next_q = 16'h0000;
    logic gap_q = 1'b0;

    // busy until the last word of the transfer has been taken
    assign ready_for_command = (left_q == 17'h00000);

    // released data shows the inverse of the last word, so stale data cannot pass
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            left_q <= 17'h00000;
            data_valid <= 1'b0;
            n_cmds <= 8'h00;
            gap_q <= 1'b0;
        end else if (cmd_valid) begin
            left_q <= (sector_count == 8'h00) ? 17'h10000 : {1'b0, sector_count, 8'h00};
            next_q <= sector_addr[15:0];
            n_cmds <= n_cmds + 8'h01;
        end else if (data_valid && data_ready) begin
            data_valid <= 1'b0;
            data <= ~data;
            left_q <= left_q - 17'h00001;
            next_q <= next_q + 16'h0001;
            gap_q <= slow;
        end else if (!data_valid && left_q != 17'h00000 && !gap_q) begin
            data_valid <= 1'b1;
            data <= next_q;
        end else begin
            gap_q <= 1'b0;
        end
    end
endmodule : hcsa_card_model

// file: bench/hcsa_top_tb.sv
// Purpose: self-checking bench for the host card sector access block.
// Assumes: byte bus mode except the last eight read bursts, which use word mode.
// Notes: sector word n is expected as 1234h plus n, after the card model's pattern.
`timescale 1ns/1ps

module hcsa_top_tb
    import hcsa_pkg::*;
;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [6:0] addr = 7'h00;
    logic [15:0] din = 16'h0000;
    logic cs_n = 1'b1, rd_n = 1'b1, wr_n = 1'b1, byte_mode = 1'b1;
    logic mode_pin = 1'b1, cfg_req = 1'b0, slow = 1'b0;
    logic [2:0] addr_pins = 3'h2;
    logic [15:0] dout, card_data;
    logic oe, bus_rdy, cmd_valid, cfg_grant, card_rdy, card_valid, card_take, start, ctrl_rst;
    logic [1:0] src;
    logic [2:0] img;
    logic [27:0] sec_addr;
    logic [7:0] sec_cnt, n_cmds;
    int mismatches = 0, n_tests = 0, cycles = 0;

    // 50 MHz system clock
    always #10 clk = ~clk;

    hcsa_top dut (.CLK(clk), .RST(rst), .HOST_ADDR(addr), .HOST_DATA_I(din),
        .HOST_DATA_O(dout), .HOST_DATA_OE(oe), .HOST_CS_N(cs_n), .HOST_RD_N(rd_n),
        .HOST_WR_N(wr_n), .HOST_BYTE_MODE(byte_mode), .BUFFER_READY_PIN(bus_rdy),
        .CONFIG_MODE_PIN(mode_pin), .CONFIG_ADDR_PINS(addr_pins), .CONFIG_SOURCE(src),
        .CONFIG_IMAGE_ADDRESS(img), .CONFIG_START(start), .CONFIG_CTRL_RESET(ctrl_rst),
        .CFG_LOCK_REQUEST(cfg_req), .CFG_LOCK_GRANT(cfg_grant),
        .CARD_READY_FOR_COMMAND(card_rdy), .CARD_CMD_VALID(cmd_valid),
        .CARD_SECTOR_ADDR(sec_addr), .CARD_SECTOR_COUNT(sec_cnt), .CARD_DATA(card_data),
        .CARD_DATA_VALID(card_valid), .CARD_DATA_READY(card_take));

    hcsa_card_model card (.clk(clk), .rst(rst), .slow(slow), .cmd_valid(cmd_valid),
        .sector_addr(sec_addr), .sector_count(sec_cnt), .ready_for_command(card_rdy),
        .n_cmds(n_cmds), .data_valid(card_valid), .data(card_data), .data_ready(card_take));

    task automatic end_sim();
        $display("comparisons %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : end_sim

    task automatic chk(input logic [27:0] got, input logic [27:0] exp);
        n_tests++;
        if (got !== exp) begin
            mismatches++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // one access per strobe; two edges held, answer taken at the releasing edge
    task automatic bus(input logic wr, input logic [6:0] a, input logic [15:0] d,
                       output logic [15:0] q);
        @(posedge clk);
        addr <= a;
        din <= d;
        cs_n <= 1'b0;
        rd_n <= wr;
        wr_n <= ~wr;
        repeat (2) @(posedge clk);
        q = dout;
        chk(oe, !wr);
        cs_n <= 1'b1;
        rd_n <= 1'b1;
        wr_n <= 1'b1;
    endtask : bus

    task automatic wb(input logic [6:0] a, input logic [7:0] d);
        logic [15:0] q;
        bus(1'b1, a, {8'h00, d}, q);
    endtask : wb

    // bounded wait, a hang here counts as a mismatch
    task automatic wait_ready();
        int i;
        for (i = 0; i < 3000 && bus_rdy !== 1'b1; i++)
            @(posedge clk);
        chk(bus_rdy, 1'b1);
    endtask : wait_ready

    task automatic t_reset();
        logic [15:0] q;
        // reset release is still pending here, so the scan controller must be held
        chk(ctrl_rst, 1'b1);
        @(posedge clk);
        chk(src, SRC_CARD);
        chk(bus_rdy, 1'b0);
        chk(ctrl_rst, 1'b0);
        wb(7'h14, 8'h01);
        wb(7'h15, CMD_READ_SECTOR);
        repeat (3) @(posedge clk);
        chk(n_cmds, 8'h00);
        bus(1'b0, OFS_STATUS, 16'h0000, q);
        chk(q[1:0], 2'b00);
        $display("test reset done");
    endtask : t_reset

    task automatic t_modes();
        logic [8:0] tab [9] = '{9'h118, 9'h138, 9'h128, 9'h108, 9'h158, 9'h178, 9'h198,
                                9'h010, 9'h018};
        logic m;
        logic [1:0] e;
        foreach (tab[i]) begin
            mode_pin <= tab[i][8];
            wb(OFS_CTRL, tab[i][7:0]);
            repeat (2) @(posedge clk);
            m = tab[i][3] ? tab[i][4] : tab[i][8];
            e = tab[i][7] ? SRC_NONE : (m ? (tab[i][6] ? SRC_HOST : SRC_CARD)
                : ((tab[i][5] && !tab[i][6]) ? SRC_CARD : SRC_NONE));
            chk(src, e);
            chk(ctrl_rst, tab[i][7]);
            chk(start, tab[i][5]);
        end
        mode_pin <= 1'b1;
        wb(OFS_CTRL + 7'h01, 8'h05);
        wb(OFS_CTRL, 8'h04);
        repeat (2) @(posedge clk);
        chk(img, 3'h5);
        wb(OFS_CTRL, 8'h00);
        repeat (2) @(posedge clk);
        chk(img, addr_pins);
        $display("test modes done");
    endtask : t_modes

    task automatic t_lock();
        logic [15:0] q;
        cfg_req <= 1'b1;
        repeat (3) @(posedge clk);
        chk(cfg_grant, 1'b1);
        bus(1'b0, OFS_STATUS, 16'h0000, q);
        chk(q[1:0], 2'b01);
        wb(OFS_CTRL, 8'h02);
        bus(1'b0, OFS_STATUS, 16'h0000, q);
        chk(q[1:0], 2'b01);
        wb(OFS_CTRL, 8'h83);
        bus(1'b0, OFS_STATUS, 16'h0000, q);
        chk(q[1:0], 2'b10);
        chk(cfg_grant, 1'b0);
        cfg_req <= 1'b0;
        wb(OFS_CTRL, 8'h02);
        $display("test lock done");
    endtask : t_lock

    task automatic t_read();
        int b, w, k;
        logic [6:0] o;
        logic [15:0] q, q2, q3;
        logic [31:0] sector_address = 32'hF5CD1234;
        bus(1'b0, 7'h05, 16'h0000, q);
        chk(q[0], 1'b1);
        for (b = 0; b < 4; b++)
            wb(OFS_LBA_LO + 7'(b), sector_address[b * 8 +: 8]);
        wb(7'h14, 8'h01);
        wb(7'h15, CMD_READ_SECTOR);
        wb(OFS_CTRL, 8'h82);
        chk(sec_addr, 28'h5CD1234);
        chk(sec_cnt, 8'h01);
        chk(n_cmds, 8'h01);
        for (b = 0; b < 16; b++) begin
            slow <= (b < 4);
            byte_mode <= (b < 8);
            wait_ready();
            chk(bus_rdy, 1'b1);
            if (b == 0) begin
                bus(1'b0, OFS_STATUS, 16'h0000, q);
                chk(q[5], 1'b1);
                wb(7'h41, 8'hAA);
            end
            // every word is drained, a short read would stall the card
            for (w = 0; w < 16; w++) begin
                k = b * 16 + w;
                if (b < 8) begin
                    o = 7'h40 + 7'((w * 2 + b * 32) % 64);
                    bus(1'b0, o, 16'h0000, q);
                    bus(1'b0, o, 16'h0000, q2);
                    bus(1'b0, o + 7'h01, 16'h0000, q3);
                    chk({q3[7:0], q[7:0]}, 16'h1234 + 16'(k));
                    chk(q2, q);
                end else begin
                    bus(1'b0, 7'h20 + 7'(w + (b % 2) * 16), 16'h0000, q);
                    chk(q, 16'h1234 + 16'(k));
                end
            end
        end
        byte_mode <= 1'b1;
        repeat (4) @(posedge clk);
        chk(bus_rdy, 1'b0);
        wb(OFS_CTRL, 8'h00);
        bus(1'b0, OFS_STATUS, 16'h0000, q);
        chk(q[1:0], 2'b00);
        $display("test read done");
    endtask : t_read

    // hang guard, the full run needs well under 10000 cycles
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            mismatches++;
            $display("Error at %0t: got %h expected %h", $time, cycles, 20000);
            end_sim();
        end
    end

    // reset for 12 cycles, then the scenarios in turn
    initial begin
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        t_reset();
        t_modes();
        t_lock();
        t_read();
        end_sim();
    end
endmodule : hcsa_top_tb
